// File: logic/eal_clkdiv.sv
// serial clock tick generator, one tick per half period of the memory clock
// assumes run stays high for a whole access
`timescale 1ns/100ps
`default_nettype none
module eal_clkdiv import eal_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] sel,
    input  wire logic       fast,
    input  wire logic       run,
    output logic            tick
);
    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } eal_div_st_t;
    eal_div_st_t r, s;
    logic [12:0] full;
    logic [11:0] half;

    always_comb begin
        unique case (sel)
            2'h0: full = DIV_0;
            2'h1: full = DIV_1;
            2'h2: full = DIV_2;
            default: full = DIV_3;
        endcase
        half = fast ? 12'(full >> (FAST_SHIFT + 1)) : 12'(full >> 1);
        s = r;
        s.tick = 1'b0;
        if (!run) begin
            s.cnt = '0;
        end else if (r.cnt == half - 12'h001) begin
            s.cnt = '0;
            s.tick = 1'b1;
        end else begin
            s.cnt = r.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) r <= '0;
        else r <= s;
    end
    assign tick = r.tick;

    // helper: cycles since last tick, valid while settings held
    logic [11:0] gap_q;
    logic        ok_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= '0;
            ok_q <= 1'b0;
        end else begin
            gap_q <= r.tick ? 12'h001 : gap_q + 12'h001;
            ok_q <= run && (r.tick ? 1'b1 : ok_q && $stable(sel) && $stable(fast));
        end
    end
    tick_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        r.tick && ok_q && $stable(sel) && $stable(fast) |-> gap_q == half)
        else $error("serial clock half period wrong");
endmodule
`default_nettype wire

// File: logic/eal_pkg.sv
// constants, types and the register map of the configuration loader
// assumes a 40 MHz single clock domain and an AXI4-Lite master
package eal_pkg;
    localparam logic [7:0] EAL_A_CTL  = 8'h70;
    localparam logic [7:0] EAL_A_RSVD = 8'h74;
    localparam logic [7:0] EAL_A_ISR  = 8'h80;
    localparam logic [7:0] EAL_A_IMSK = 8'h84;
    localparam int B_GO   = 0;
    localparam int B_CMD  = 1;
    localparam int B_ERR  = 2;
    localparam int B_DONE = 3;
    localparam int B_DIV  = 4;
    localparam int B_ALD  = 6;
    localparam int B_FAST = 7;
    localparam int B_BUSY = 8;
    localparam int B_WA   = 9;
    localparam int B_DAT  = 16;
    localparam logic [1:0] DIV_RST  = 2'h0;
    localparam logic       FAST_RST = 1'b1;
    localparam logic       ALD_RST  = 1'b0;
    localparam logic [12:0] DIV_0 = 13'h1000;
    localparam logic [12:0] DIV_1 = 13'h0800;
    localparam logic [12:0] DIV_2 = 13'h0400;
    localparam logic [12:0] DIV_3 = 13'h0080;
    localparam int FAST_SHIFT = 5;
    localparam logic [4:0] FR_LAST = 5'h19;
    localparam logic [4:0] FR_ACK1 = 5'h08;
    localparam logic [4:0] FR_DLO  = 5'h09;
    localparam logic [4:0] FR_DHI  = 5'h18;
    localparam logic [6:0] AL_LAST = 7'h07;
    localparam int IRQ_SW  = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_AL  = 2;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;
    typedef enum logic [3:0] {
        MS_BOOT = 4'h1,
        MS_IDLE = 4'h2,
        MS_AL   = 4'h4,
        MS_SW   = 4'h8
    } eal_mst_t;
    typedef enum logic [3:0] {
        XS_IDLE  = 4'h1,
        XS_START = 4'h2,
        XS_BIT   = 4'h4,
        XS_STOP  = 4'h8
    } eal_xst_t;
endpackage

// File: logic/eal_top.sv
// configuration memory loader: control/status register on AXI4-Lite,
// boot-time autoload, single word accesses and an interrupt
// assumes a two-wire serial memory with pull-up on the data line
`timescale 1ns/100ps
`default_nettype none
module eal_top import eal_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             ee_scl,
    input  wire logic        ee_sda_i,
    output logic             ee_sda_o,
    output logic             ee_sda_oe_n,
    output logic             cfg_we,
    output logic [6:0]       cfg_addr,
    output logic [15:0]      cfg_data,
    output logic             irq
);
    typedef struct packed {
        eal_mst_t    st;
        logic        go;
        logic        cmd;
        logic        err;
        logic        done;
        logic [1:0]  div;
        logic        ald;
        logic        fast;
        logic [6:0]  wa;
        logic [15:0] dat;
        logic [2:0]  isr;
        logic [2:0]  imsk;
        logic [6:0]  al_cnt;
        logic        xstart;
        logic        aw_h;
        logic        w_h;
        logic [7:0]  awa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        awrdy;
        logic        wrdy;
        logic        bvld;
        logic [1:0]  bresp;
        logic        arrdy;
        logic        rvld;
        logic [31:0] rd;
        logic [1:0]  rresp;
        logic        cfg_we;
        logic [6:0]  cfg_a;
        logic [15:0] cfg_d;
        logic        irq;
    } eal_top_st_t;

    eal_top_st_t r, s;
    logic        tick;
    logic        xbusy;
    logic        xdone;
    logic        xerr;
    logic [15:0] xrd;
    logic        x_wr;
    logic [6:0]  x_addr;
    logic [31:0] ctl;
    logic [31:0] m;
    logic [31:0] nw;

    ////////////////////////////////////////////////////////////////
    // serial side

    // autoload always reads; software accesses follow the command bit
    assign x_wr = (r.st == MS_AL) ? 1'b0 : r.cmd;
    assign x_addr = (r.st == MS_AL) ? r.al_cnt : r.wa;

    eal_clkdiv u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .sel   (r.div),
        .fast  (r.fast && r.st == MS_AL),
        .run   (xbusy),
        .tick  (tick)
    );

    eal_xfer u_xfer (
        .clk      (clk),
        .rst_n    (rst_n),
        .tick     (tick),
        .start    (r.xstart),
        .wr       (x_wr),
        .addr     (x_addr),
        .wdata    (r.dat),
        .sda_i    (ee_sda_i),
        .busy     (xbusy),
        .done     (xdone),
        .err      (xerr),
        .rdata    (xrd),
        .scl      (ee_scl),
        .sda_o    (ee_sda_o),
        .sda_oe_n (ee_sda_oe_n)
    );

    ////////////////////////////////////////////////////////////////
    // register image and next state

    always_comb begin
        ctl = '0;
        ctl[B_GO] = r.go;
        ctl[B_CMD] = r.cmd;
        ctl[B_ERR] = r.err;
        ctl[B_DONE] = r.done;
        ctl[B_DIV +: 2] = r.div;
        ctl[B_ALD] = r.ald;
        ctl[B_FAST] = r.fast;
        ctl[B_BUSY] = r.st == MS_AL;
        ctl[B_WA +: 7] = r.wa;
        ctl[B_DAT +: 16] = r.dat;
        m = {{8{r.ws[3]}}, {8{r.ws[2]}}, {8{r.ws[1]}}, {8{r.ws[0]}}};
        nw = (ctl & ~m) | (r.wd & m);

        s = r;
        s.xstart = 1'b0;
        s.cfg_we = 1'b0;

        // read channel, one outstanding read
        if (s_axi_arvalid && r.arrdy) begin
            s.arrdy = 1'b0;
            s.rvld = 1'b1;
            s.rresp = RESP_OK;
            unique case (s_axi_araddr)
                EAL_A_CTL: s.rd = ctl;
                EAL_A_RSVD: s.rd = '0;
                EAL_A_ISR: s.rd = {29'h0, r.isr};
                EAL_A_IMSK: s.rd = {29'h0, r.imsk};
                default: begin
                    s.rd = '0;
                    s.rresp = RESP_DEC;
                end
            endcase
        end
        if (r.rvld && s_axi_rready) begin
            s.rvld = 1'b0;
            s.arrdy = 1'b1;
        end

        // write channel: address and data taken in either order
        if (s_axi_awvalid && r.awrdy) begin
            s.aw_h = 1'b1;
            s.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && r.wrdy) begin
            s.w_h = 1'b1;
            s.wd = s_axi_wdata;
            s.ws = s_axi_wstrb;
        end
        if (r.aw_h && r.w_h && !r.bvld) begin
            s.aw_h = 1'b0;
            s.w_h = 1'b0;
            s.bvld = 1'b1;
            s.bresp = RESP_OK;
            unique case (r.awa)
                EAL_A_CTL: begin
                    s.cmd = nw[B_CMD];
                    s.div = nw[B_DIV +: 2];
                    s.ald = nw[B_ALD];
                    s.fast = nw[B_FAST];
                    s.wa = nw[B_WA +: 7];
                    s.dat = nw[B_DAT +: 16];
                    // a launch is only honoured while nothing runs
                    if (nw[B_GO] && !r.go && r.st == MS_IDLE) begin
                        s.go = 1'b1;
                        s.err = 1'b0;
                        s.st = MS_SW;
                        s.xstart = 1'b1;
                    end
                end
                EAL_A_RSVD: s.bresp = RESP_OK;
                EAL_A_ISR: s.isr = r.isr & ~(r.wd[2:0] & m[2:0]);
                EAL_A_IMSK: s.imsk = nw[2:0];
                default: s.bresp = RESP_DEC;
            endcase
        end
        if (r.bvld && s_axi_bready) s.bvld = 1'b0;

        // access sequencing; event sets come after the clears above
        unique case (r.st)
            MS_BOOT: begin
                if (!r.ald) begin
                    s.st = MS_AL;
                    s.al_cnt = '0;
                    s.xstart = 1'b1;
                end else begin
                    s.st = MS_IDLE;
                end
            end
            MS_IDLE: ;
            MS_AL: if (xdone) begin
                if (xerr) begin
                    s.err = 1'b1;
                    s.isr[IRQ_ERR] = 1'b1;
                    s.st = MS_IDLE;
                end else begin
                    s.cfg_we = 1'b1;
                    s.cfg_a = r.al_cnt;
                    s.cfg_d = xrd;
                    if (r.al_cnt == AL_LAST) begin
                        s.done = 1'b1;
                        s.isr[IRQ_AL] = 1'b1;
                        s.st = MS_IDLE;
                    end else begin
                        s.al_cnt = r.al_cnt + 7'h01;
                        s.xstart = 1'b1;
                    end
                end
            end
            MS_SW: if (xdone) begin
                s.go = 1'b0;
                s.err = xerr;
                if (!r.cmd) s.dat = xrd;
                s.isr[IRQ_SW] = 1'b1;
                if (xerr) s.isr[IRQ_ERR] = 1'b1;
                s.st = MS_IDLE;
            end
        endcase

        s.awrdy = !s.aw_h && !s.bvld;
        s.wrdy = !s.w_h && !s.bvld;
        s.irq = |(s.isr & s.imsk);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= MS_BOOT;
            r.div <= DIV_RST;
            r.ald <= ALD_RST;
            r.fast <= FAST_RST;
            r.awrdy <= 1'b1;
            r.wrdy <= 1'b1;
            r.arrdy <= 1'b1;
        end else begin
            r <= s;
        end
    end

    assign s_axi_awready = r.awrdy;
    assign s_axi_wready = r.wrdy;
    assign s_axi_bresp = r.bresp;
    assign s_axi_bvalid = r.bvld;
    assign s_axi_arready = r.arrdy;
    assign s_axi_rdata = r.rd;
    assign s_axi_rresp = r.rresp;
    assign s_axi_rvalid = r.rvld;
    assign cfg_we = r.cfg_we;
    assign cfg_addr = r.cfg_a;
    assign cfg_data = r.cfg_d;
    assign irq = r.irq;

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence sw_rd_end;
        r.st == MS_SW && !r.cmd && xdone;
    endsequence
    sequence al_word_ok;
        r.st == MS_AL && xdone && !xerr;
    endsequence

    launch_start_a: assert property ($rose(r.go) |-> r.xstart && r.st == MS_SW)
        else $error("initiate rise without access start");
    go_clear_a: assert property (r.st == MS_SW && xdone |=> !r.go && r.st == MS_IDLE)
        else $error("initiate bit not cleared at end of access");
    err_flag_a: assert property (r.st != MS_IDLE && xdone && xerr |=> r.err)
        else $error("error flag not set on missing ack");
    complete_a: assert property ($rose(r.done) |-> $past(r.st) == MS_AL && !r.err)
        else $error("completion set outside a clean autoload");
    skip_al_a: assert property (r.st == MS_BOOT |=> (r.st == MS_AL) == !$past(r.ald))
        else $error("autoload enable ignored at boot");
    fast_sel_a: assert property (r.st == MS_AL && xbusy |-> u_div.fast == r.fast)
        else $error("fast load not applied during autoload");
    busy_read_a: assert property (s_axi_arvalid && r.arrdy && s_axi_araddr == EAL_A_CTL
        |=> s_axi_rdata[B_BUSY] == ($past(r.st) == MS_AL))
        else $error("in-progress flag does not track autoload");
    rd_word_a: assert property (sw_rd_end |=> r.dat == $past(xrd))
        else $error("read word not placed in data field");
    al_store_a: assert property (al_word_ok |=> cfg_we ##1 !cfg_we)
        else $error("autoload word not delivered");
    irq_level_a: assert property (|(r.isr & r.imsk) |-> irq)
        else $error("interrupt low with unmasked status");
endmodule
`default_nettype wire

// File: logic/eal_xfer.sv
// bit engine for one memory word access: start, command byte, ack,
// sixteen data bits, ack or no-ack, stop
// assumes tick pulses from eal_clkdiv and a pulled-up data line
`timescale 1ns/100ps
`default_nettype none
module eal_xfer import eal_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [6:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        sda_i,
    output logic             busy,
    output logic             done,
    output logic             err,
    output logic [15:0]      rdata,
    output logic             scl,
    output logic             sda_o,
    output logic             sda_oe_n
);
    typedef struct packed {
        eal_xst_t    st;
        logic        ph;
        logic [4:0]  idx;
        logic [25:0] fr;
        logic        wr;
        logic [15:0] rd;
        logic        err;
        logic        done;
        logic        scl;
        logic        sda;
        logic        oe_n;
    } eal_xf_st_t;
    eal_xf_st_t r, s;
    logic [4:0] nx;
    logic       rel;
    logic       isdat;

    always_comb begin
        s = r;
        s.done = 1'b0;
        nx = r.idx + 5'h01;
        if (r.scl) nx = r.idx + 5'h01;
        else nx = r.idx;
        isdat = nx >= FR_DLO && nx <= FR_DHI;
        // the memory drives its acks and the read data; we release then
        rel = nx == FR_ACK1 || (isdat && !r.wr) || (nx == FR_LAST && r.wr);
        unique case (r.st)
            XS_IDLE: begin
                s.scl = 1'b1;
                s.sda = 1'b1;
                s.oe_n = 1'b1;
                if (start) begin
                    s.st = XS_START;
                    s.fr = {wr, addr, 1'b1, wdata, 1'b1};
                    s.wr = wr;
                    // all ones wraps to slot 0 at the first low half, so bit 25 is sent
                    s.idx = '1;
                    s.err = 1'b0;
                    s.oe_n = 1'b0;
                end
            end
            XS_START: if (tick) begin
                s.sda = 1'b0;
                s.st = XS_BIT;
                s.ph = 1'b0;
            end
            XS_BIT: if (tick) begin
                if (!r.ph) begin
                    if (r.scl) begin
                        if ((r.idx == FR_ACK1 || (r.wr && r.idx == FR_LAST)) && sda_i)
                            s.err = 1'b1;
                        if (!r.wr && r.idx >= FR_DLO && r.idx <= FR_DHI)
                            s.rd = {r.rd[14:0], sda_i};
                    end
                    s.scl = 1'b0;
                    s.ph = 1'b1;
                    if (r.scl && r.idx == FR_LAST) begin
                        s.st = XS_STOP;
                        s.ph = 1'b0;
                        s.sda = 1'b0;
                        s.oe_n = 1'b0;
                    end else begin
                        s.idx = nx;
                        s.sda = rel ? 1'b1 : r.fr[FR_LAST - nx];
                        s.oe_n = rel;
                    end
                end else begin
                    s.scl = 1'b1;
                    s.ph = 1'b0;
                end
            end
            XS_STOP: if (tick) begin
                if (!r.ph) begin
                    s.scl = 1'b1;
                    s.ph = 1'b1;
                end else begin
                    s.sda = 1'b1;
                    s.oe_n = 1'b1;
                    s.done = 1'b1;
                    s.st = XS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= XS_IDLE;
            r.scl <= 1'b1;
            r.sda <= 1'b1;
            r.oe_n <= 1'b1;
        end else begin
            r <= s;
        end
    end

    assign busy = r.st != XS_IDLE;
    assign done = r.done;
    assign err = r.err;
    assign rdata = r.rd;
    assign scl = r.scl;
    assign sda_o = r.sda;
    assign sda_oe_n = r.oe_n;

    wr_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        r.st == XS_BIT && r.wr && r.idx >= FR_DLO && r.idx <= FR_DHI
        |-> !r.oe_n && r.sda == r.fr[FR_LAST - r.idx])
        else $error("write data bit not driven from data field");
    ack_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        r.st == XS_BIT && tick && !r.ph && r.scl && r.idx == FR_ACK1 && sda_i
        |=> r.err)
        else $error("missing ack did not raise error");
endmodule
`default_nettype wire

// File: test/eal_mem_model.sv
// serial memory model: 128 words, acknowledges every frame unless refuse is high
// assumes a pull-up on the data line and scl driven by the host
`timescale 1ns/100ps
`default_nettype none
module eal_mem_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic refuse,
    output logic      pull_low
);
    logic [15:0] mem [0:127];
    logic [7:0]  cmd;
    logic [15:0] sh;
    int          n;
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 16'hC300 | 16'(i);
        end
        pull_low = 1'b0;
        n = -1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // start and stop are the only sda edges while scl is high
    always @(sda) begin
        // data moves in the same step as the scl fall; let scl settle first
        #1;
        if (scl === 1'b1) begin
            n = sda ? -1 : 0;
            pull_low = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (n >= 0 && n < 8) cmd = {cmd[6:0], sda};
        if (n > 8 && n < 25) sh = {sh[14:0], sda};
        if (n == 25 && cmd[7] && !refuse) mem[cmd[6:0]] = sh;
        if (n >= 0) n++;
    end
    // released slots float to the pull-up, never the last value
    always @(negedge scl) begin
        if (n >= 0) begin
            pull_low = 1'b0;
            if ((n == 8 || (n == 25 && cmd[7])) && !refuse) pull_low = 1'b1;
            if (n > 8 && n < 25 && !cmd[7]) pull_low = !mem[cmd[6:0]][24 - n];
        end
    end
endmodule
`default_nettype wire

// File: test/eal_tb_top.sv
// register-level bench for eal_top over AXI4-Lite
// assumes eal_mem_model on the serial pins and a 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module eal_tb_top import eal_pkg::*; ();
    logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, ee_scl, ee_sda_i, ee_sda_o, ee_sda_oe_n, cfg_we, irq;
    logic        refuse, pull_low;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [6:0]  cfg_addr;
    logic [15:0] cfg_data;
    int          num_errors, n_tests, cyc, n_cfg, per_mid;
    realtime     t_rise;
    assign ee_sda_i = (ee_sda_oe_n ? 1'b1 : ee_sda_o) & !pull_low;
    eal_top DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ee_scl, .ee_sda_i, .ee_sda_o, .ee_sda_oe_n, .cfg_we,
        .cfg_addr, .cfg_data, .irq);
    eal_mem_model u_mem (.scl(ee_scl), .sda(ee_sda_i), .refuse, .pull_low);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one transfer; read data and response land in q and r
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = w;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && (w ? s_axi_awready : s_axi_arready)) begin
                pa = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (pw && s_axi_wready) begin
                pw = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= w;
        s_axi_rready <= !w;
        do @(posedge clk); while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        q = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task automatic poll(input int b);
        do xfer(1'b0, EAL_A_CTL, 32'h0); while (q[b] !== 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // serial period sampled mid command byte, clear of start and stop
    always @(posedge ee_scl) begin
        if (u_mem.n > 2 && u_mem.n < 6) per_mid = int'(($realtime - t_rise) / 25.0);
        t_rise = $realtime;
    end
    always @(posedge clk) begin
        if (cfg_we === 1'b1) begin
            chk("cfg_addr", 32'(n_cfg), 32'(cfg_addr));
            chk("cfg_data", 32'(16'hC300 | 16'(n_cfg)), 32'(cfg_data));
            n_cfg++;
        end
        cyc++;
        if (cyc == 100000) begin
            num_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, refuse, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, EAL_A_CTL, 32'h0);
        chk("ctl_boot", 32'h00000180, q);
        poll(B_BUSY);
        chk("ctl_loaded", 32'h00000088, q & 32'h000001FF);
        chk("al_words", 32'd8, 32'(n_cfg));
        chk("al_period", 32'd128, 32'(per_mid));
        xfer(1'b0, EAL_A_ISR, 32'h0);
        chk("isr_al", 32'h4, q);
        // write 8ABB to word 45h, fastest divider
        xfer(1'b1, EAL_A_CTL, 32'h8ABB8AB3);
        poll(B_GO);
        chk("wr_err", 32'h0, q & 32'h5);
        chk("mem_45", 32'h8ABB, 32'(u_mem.mem[7'h45]));
        chk("wr_period", 32'd128, 32'(per_mid));
        xfer(1'b0, EAL_A_ISR, 32'h0);
        chk("isr_wr", 32'h5, q);
        chk("irq_off", 32'h0, 32'(irq));
        xfer(1'b1, EAL_A_ISR, 32'h7);
        // read it back with data field zeroed, divider 1024
        xfer(1'b1, EAL_A_CTL, 32'h00008AA1);
        poll(B_GO);
        chk("rd_data", 32'h8ABB0000, q & 32'hFFFF0005);
        chk("rd_period", 32'd1024, 32'(per_mid));
        // refused acknowledge with the error interrupt unmasked
        xfer(1'b1, EAL_A_IMSK, 32'h2);
        refuse <= 1'b1;
        xfer(1'b1, EAL_A_CTL, 32'h000000B1);
        poll(B_GO);
        chk("nack_err", 32'h4, q & 32'h4);
        chk("irq_on", 32'h1, 32'(irq));
        xfer(1'b1, EAL_A_ISR, 32'h3);
        xfer(1'b0, EAL_A_ISR, 32'h0);
        chk("isr_clr", 32'h0, q);
        chk("irq_clr", 32'h0, 32'(irq));
        refuse <= 1'b0;
        xfer(1'b1, EAL_A_CTL, 32'h000000B1);
        poll(B_GO);
        chk("ack_ok", 32'h0, q & 32'h4);
        xfer(1'b1, EAL_A_RSVD, 32'hFFFFFFFF);
        chk("rsvd_wr", 32'(RESP_OK), 32'(r));
        xfer(1'b0, EAL_A_RSVD, 32'h0);
        chk("rsvd_rd", 32'h0, q);
        xfer(1'b0, 8'h90, 32'h0);
        chk("unmap", 32'(RESP_DEC), 32'(r));
        complete_run();
    end
endmodule
`default_nettype wire
